//--- logic/imp_pkg.sv
/*
 * Constants shared by the interrupt aggregation block and the core end.
 * Assumes the registers are reached as 32-bit Wishbone words, one per index.
 */
`default_nettype none
package imp_pkg;
   localparam int NUM_SRC = 24;
   localparam int NUM_LEVEL = 16;
   localparam int NUM_EDGE = 8;
   localparam int SRC_ID_W = 5;
   localparam int IDX_W = 12;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_MASK_LEVEL_LOW = 12'h640;
   localparam logic [IDX_W-1:0] IDX_MASK_LEVEL_HIGH = 12'h641;
   localparam logic [IDX_W-1:0] IDX_MASK_EDGE = 12'h642;
   localparam logic [IDX_W-1:0] IDX_GLOBAL_CONTROL = 12'h643;
   localparam logic [IDX_W-1:0] IDX_URGENCY_BYTE0 = 12'h644;
   localparam logic [IDX_W-1:0] IDX_URGENCY_BYTE1 = 12'h645;
   localparam logic [IDX_W-1:0] IDX_URGENCY_BYTE2 = 12'h646;
   localparam logic [IDX_W-1:0] IDX_PENDING_BYTE0 = 12'h648;
   localparam logic [IDX_W-1:0] IDX_PENDING_BYTE1 = 12'h649;
   localparam logic [IDX_W-1:0] IDX_PENDING_BYTE2 = 12'h64A;
   localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 12'h650;
   localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 12'h651;

   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] URGENCY_RESET = 8'h00;
   localparam logic [7:0] EVENT_RESET = 8'h00;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic [7:0] CONTROL_WRITABLE = 8'h03;
   localparam logic [7:0] EDGE_WRITABLE = 8'h7F;

   // Source positions in the 24-bit word.
   localparam int SRC_COUNTER0 = 0;
   localparam int SRC_COUNTER1 = 1;
   localparam int SRC_COUNTER2 = 2;
   localparam int SRC_USB_PWDN = 3;
   localparam int SRC_DMA = 4;
   localparam int SRC_DFIFO = 5;
   localparam int SRC_SERIAL = 6;
   localparam int SRC_HOST_CMD = 7;
   localparam int SRC_USB_DEV0 = 8;
   localparam int SRC_BASEBAND = 13;
   localparam int SRC_PWM = 14;
   localparam int SRC_PKE = 15;
   localparam int SRC_BUS_IDLE = 16;
   localparam int SRC_USB_RESET = 17;
   localparam int SRC_GPIO = 18;
   localparam int SRC_WAKE_TIMER = 19;
   localparam int SRC_SYS_TIMER = 20;
   localparam int SRC_PIN_ROUTED0 = 21;
   localparam int SRC_RSVD = 23;

   localparam int EVT_ACCEPTED = 0;
   localparam int EVT_EDGE_CAUGHT = 1;
   localparam logic [7:0] EVENT_WRITABLE = 8'h03;

   typedef enum logic [1:0] {
      IMP_IDLE = 2'b00,
      IMP_TAKE = 2'b01,
      IMP_SERVE = 2'b11,
      IMP_BACK = 2'b10
   } imp_core_state_t;
endpackage
`default_nettype wire

//--- logic/imp_link_if.sv
/*
 * Link between the interrupt aggregation block and the processor core end.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface imp_link_if;
   logic req;
   logic [imp_pkg::SRC_ID_W-1:0] src_id;
   logic src_high;
   logic ack;

   modport dev (output req, output src_id, output src_high, input ack);
   modport core (input req, input src_id, input src_high, output ack);
endinterface
`default_nettype wire

//--- logic/imp_core_end.sv
/*
 * Processor core end: takes requests from the aggregation block and steps
 * through handler entry, service and resume.
 * Assumes the handler signals its end on HANDLER_DONE_I.
 */
`timescale 1ns/100ps
`default_nettype none
module imp_core_end (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic CE_I,
   input wire logic ACCEPT_EN_I,
   input wire logic HANDLER_DONE_I,
   output logic IN_HANDLER_O,
   output logic [imp_pkg::SRC_ID_W-1:0] TAKEN_SRC_O,
   output logic TAKEN_HIGH_O,
   output logic RESUME_O,
   imp_link_if.core LINK
);
   imp_pkg::imp_core_state_t state_q;
   imp_pkg::imp_core_state_t state_d;
   logic [imp_pkg::SRC_ID_W-1:0] src_q;
   logic high_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         imp_pkg::IMP_IDLE: begin
            // The core decides whether to take a request.
            if (LINK.req && ACCEPT_EN_I) begin
               state_d = imp_pkg::IMP_TAKE;
            end
         end
         imp_pkg::IMP_TAKE: begin
            state_d = imp_pkg::IMP_SERVE;
         end
         imp_pkg::IMP_SERVE: begin
            if (HANDLER_DONE_I) begin
               state_d = imp_pkg::IMP_BACK;
            end
         end
         imp_pkg::IMP_BACK: begin
            state_d = imp_pkg::IMP_IDLE;
         end
         default: begin
            state_d = imp_pkg::IMP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_q <= imp_pkg::IMP_IDLE;
      end else if (CE_I) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         src_q <= '0;
         high_q <= 1'b0;
      end else if (CE_I && state_q == imp_pkg::IMP_IDLE && state_d == imp_pkg::IMP_TAKE) begin
         src_q <= LINK.src_id;
         high_q <= LINK.src_high;
      end
   end

   assign LINK.ack = CE_I && (state_q == imp_pkg::IMP_TAKE);
   assign IN_HANDLER_O = (state_q == imp_pkg::IMP_SERVE);
   assign RESUME_O = CE_I && (state_q == imp_pkg::IMP_BACK);
   assign TAKEN_SRC_O = src_q;
   assign TAKEN_HIGH_O = high_q;
endmodule
`default_nettype wire

//--- logic/imp_irq_unit.sv
/*
 * Interrupt aggregation block: 24 sources, masks, master enable, urgency,
 * pending flags, a request to the core and a classic Wishbone slave.
 * Assumes source lines are synchronous to CLK_I and the core end sits on LINK.
 */
// The Wishbone interface to the registers was chosen for this implementation.
// Operation
// - Take 16 level and 8 edge sources.
// - One mask bit per source, 1 enables.
// - Level byte zero holds host..counter0 sources.
// - Level byte one holds PKE, PWM, baseband, USB.
// - Edge byte holds pins, timers, GPIO, USB.
// - Control bit 0 is the master enable.
// - Urgency bytes mark each source high or low.
// - High urgency sources are presented first.
// - Software leaves urgency at zero.
// - A raised source sets its pending flag.
// - Pending bytes form one word, byte zero lowest.
// - Edge flags stick until written with one.
// - Level flags follow their module's own status.
// - Counter0 shows at bit 0 when enabled.
// - The core chooses, serves, then resumes.
// - Counter2 request marks end of pulse measure.
`timescale 1ns/100ps
`default_nettype none
module imp_irq_unit (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic CE_I,
   input wire logic [imp_pkg::NUM_LEVEL-1:0] LEVEL_SRC_I,
   input wire logic [imp_pkg::NUM_EDGE-1:0] EDGE_SRC_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [31:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   output logic IRQ_O,
   imp_link_if.dev LINK
);
   logic [imp_pkg::NUM_SRC-1:0] mask_q;
   logic [imp_pkg::NUM_SRC-1:0] urgency_q;
   logic [7:0] control_q;
   logic [imp_pkg::NUM_LEVEL-1:0] level_q;
   logic [imp_pkg::NUM_EDGE-1:0] edge_prev_q;
   logic [imp_pkg::NUM_EDGE-1:0] edge_flag_q;
   logic [imp_pkg::NUM_EDGE-1:0] edge_rise;
   logic [imp_pkg::NUM_EDGE-1:0] edge_clear;
   logic [7:0] evt_status_q;
   logic [7:0] evt_mask_q;
   logic [7:0] evt_set;
   logic [imp_pkg::NUM_SRC-1:0] raw_pending;
   logic [imp_pkg::NUM_SRC-1:0] shown;
   logic [imp_pkg::NUM_SRC-1:0] high_set;
   logic [imp_pkg::NUM_SRC-1:0] low_set;
   logic master_en;
   logic ack_q;
   logic [31:0] dat_q;
   logic bus_req;
   logic bus_wr;
   logic [imp_pkg::IDX_W-1:0] idx;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic req_q;
   logic [imp_pkg::SRC_ID_W-1:0] src_id_q;
   logic src_high_q;

   // Lowest set bit wins among equal urgency, so the order is fixed and known.
   function automatic logic [imp_pkg::SRC_ID_W-1:0] first_set(
      input logic [imp_pkg::NUM_SRC-1:0] v);
      logic [imp_pkg::SRC_ID_W-1:0] r;
      r = '0;
      for (int i = imp_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = imp_pkg::SRC_ID_W'(i);
         end
      end
      return r;
   endfunction

   assign bus_req = CYC_I && STB_I;
   // A write lands at the edge where the master sees ack high.
   assign bus_wr = bus_req && WE_I && SEL_I[0] && ack_q;
   assign idx = ADR_I[imp_pkg::IDX_W+1:2];
   assign wbyte = DAT_I[7:0];
   assign master_en = control_q[imp_pkg::CTRL_ENABLE_BIT];

   // Level group fills bytes zero and one, edge group byte two.
   assign raw_pending = {edge_flag_q, level_q};
   // Flags read as pending, masked and enabled.
   assign shown = raw_pending & mask_q & {imp_pkg::NUM_SRC{master_en}};
   assign high_set = shown & urgency_q;
   assign low_set = shown & ~urgency_q;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (CE_I) begin
         ack_q <= bus_req && !ack_q;
         if (bus_req && !ack_q) begin
            dat_q <= {24'h00_0000, rbyte};
         end
      end
   end

   always_comb begin
      rbyte = 8'h00;
      case (idx)
         imp_pkg::IDX_MASK_LEVEL_LOW: rbyte = mask_q[7:0];
         imp_pkg::IDX_MASK_LEVEL_HIGH: rbyte = mask_q[15:8];
         imp_pkg::IDX_MASK_EDGE: rbyte = mask_q[23:16];
         imp_pkg::IDX_GLOBAL_CONTROL: rbyte = control_q;
         imp_pkg::IDX_URGENCY_BYTE0: rbyte = urgency_q[7:0];
         imp_pkg::IDX_URGENCY_BYTE1: rbyte = urgency_q[15:8];
         imp_pkg::IDX_URGENCY_BYTE2: rbyte = urgency_q[23:16];
         imp_pkg::IDX_PENDING_BYTE0: rbyte = shown[7:0];
         imp_pkg::IDX_PENDING_BYTE1: rbyte = shown[15:8];
         imp_pkg::IDX_PENDING_BYTE2: rbyte = shown[23:16];
         imp_pkg::IDX_EVENT_STATUS: rbyte = evt_status_q;
         imp_pkg::IDX_EVENT_MASK: rbyte = evt_mask_q;
         default: rbyte = 8'h00;
      endcase
   end

   // Mask bytes: byte zero and one per level layout, byte two per edge layout.
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_q <= {imp_pkg::MASK_RESET, imp_pkg::MASK_RESET, imp_pkg::MASK_RESET};
      end else if (CE_I && bus_wr) begin
         if (idx == imp_pkg::IDX_MASK_LEVEL_LOW) begin
            mask_q[7:0] <= wbyte;
         end
         if (idx == imp_pkg::IDX_MASK_LEVEL_HIGH) begin
            mask_q[15:8] <= wbyte;
         end
         if (idx == imp_pkg::IDX_MASK_EDGE) begin
            mask_q[23:16] <= wbyte & imp_pkg::EDGE_WRITABLE;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         control_q <= imp_pkg::CONTROL_RESET;
      end else if (CE_I && bus_wr && idx == imp_pkg::IDX_GLOBAL_CONTROL) begin
         control_q <= wbyte & imp_pkg::CONTROL_WRITABLE;
      end
   end

   // Urgency is writable, though software is expected to keep it at zero.
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         urgency_q <= {imp_pkg::URGENCY_RESET, imp_pkg::URGENCY_RESET,
                       imp_pkg::URGENCY_RESET};
      end else if (CE_I && bus_wr) begin
         if (idx == imp_pkg::IDX_URGENCY_BYTE0) begin
            urgency_q[7:0] <= wbyte;
         end
         if (idx == imp_pkg::IDX_URGENCY_BYTE1) begin
            urgency_q[15:8] <= wbyte;
         end
         if (idx == imp_pkg::IDX_URGENCY_BYTE2) begin
            urgency_q[23:16] <= wbyte & imp_pkg::EDGE_WRITABLE;
         end
      end
   end

   // Level flags mirror the module status one cycle late; the counter2 line
   // carries the end of a pulse-width measurement from its timer.
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         level_q <= '0;
      end else if (CE_I) begin
         level_q <= LEVEL_SRC_I;
      end
   end

   assign edge_clear = (bus_wr && idx == imp_pkg::IDX_PENDING_BYTE2) ?
                       wbyte : 8'h00;

   genvar g;
   generate
      for (g = 0; g < imp_pkg::NUM_EDGE; g++) begin : g_edge
         assign edge_rise[g] = EDGE_SRC_I[g] && !edge_prev_q[g] && (g != 7);
         always_ff @(posedge CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               edge_prev_q[g] <= 1'b0;
               edge_flag_q[g] <= 1'b0;
            end else if (CE_I) begin
               edge_prev_q[g] <= EDGE_SRC_I[g];
               // A new edge in the clearing cycle is kept.
               if (edge_rise[g]) begin
                  edge_flag_q[g] <= 1'b1;
               end else if (edge_clear[g]) begin
                  edge_flag_q[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Request and chosen source are registered so they stay stable for the core.
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         req_q <= 1'b0;
         src_id_q <= '0;
         src_high_q <= 1'b0;
      end else if (CE_I) begin
         req_q <= |shown;
         src_high_q <= |high_set;
         src_id_q <= (|high_set) ? first_set(high_set) : first_set(low_set);
      end
   end

   assign evt_set = {6'b00_0000, |edge_rise, LINK.ack};

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         evt_status_q <= imp_pkg::EVENT_RESET;
         evt_mask_q <= imp_pkg::EVENT_RESET;
      end else if (CE_I) begin
         if (bus_wr && idx == imp_pkg::IDX_EVENT_STATUS) begin
            evt_status_q <= ((evt_status_q & ~wbyte) | evt_set) & imp_pkg::EVENT_WRITABLE;
         end else begin
            evt_status_q <= (evt_status_q | evt_set) & imp_pkg::EVENT_WRITABLE;
         end
         if (bus_wr && idx == imp_pkg::IDX_EVENT_MASK) begin
            evt_mask_q <= wbyte & imp_pkg::EVENT_WRITABLE;
         end
      end
   end

   assign LINK.req = req_q;
   assign LINK.src_id = src_id_q;
   assign LINK.src_high = src_high_q;
   assign ACK_O = ack_q;
   assign DAT_O = dat_q;
   assign IRQ_O = |(evt_status_q & evt_mask_q);
endmodule
`default_nettype wire

//--- verif/imp_link_props.sv
/*
 * Checker for the link between the aggregation block and the core end.
 * Assumes it sits beside the one link interface in the bench top.
 */
`timescale 1ns/100ps
`default_nettype none
module imp_link_props (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic req_i,
   input wire logic [imp_pkg::SRC_ID_W-1:0] src_id_i,
   input wire logic src_high_i,
   input wire logic ack_i
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   // The core must pass through service and resume before taking again.
   a_ack_gap: assert property (ack_i |=> !ack_i [*3])
      else $error("link ack too soon");
   a_ack_cause: assert property (ack_i |-> $past(req_i))
      else $error("ack without request");
   a_src_range: assert property (req_i |-> src_id_i < 5'h17)
      else $error("bad source id");
   a_fell_quiet: assert property ($fell(ack_i) |-> !ack_i [*2])
      else $error("ack bounced");
   // An urgent choice can only be offered while something is requested.
   a_high_needs_req: assert property (src_high_i |-> req_i)
      else $error("urgent source without request");
   a_idle_source: assert property (!req_i |-> !src_high_i && src_id_i == 5'h00)
      else $error("source offered while idle");
   c_take: cover property (req_i ##1 ack_i);
endmodule
`default_nettype wire

//--- verif/tb.sv
/*
 * Self-checking bench: the aggregation block and the core end joined by
 * the link, registers reached over classic Wishbone.
 * Assumes the package and link interface are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk, arst_n, cyc, stb, we, ack, irq, accept, hdone, in_h, thigh, resume;
   logic [15:0] lvl;
   logic [7:0] edg;
   logic [31:0] adr, dat_i, dat_o;
   logic [3:0] sel;
   logic [4:0] tsrc;
   logic [7:0] rd;
   int mismatches, checks_done, cycles;

   imp_link_if link();
   imp_irq_unit imp_irq_unit_inst (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
      .LEVEL_SRC_I(lvl), .EDGE_SRC_I(edg), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
      .IRQ_O(irq), .LINK(link));
   imp_core_end imp_core_end_inst (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
      .ACCEPT_EN_I(accept), .HANDLER_DONE_I(hdone), .IN_HANDLER_O(in_h),
      .TAKEN_SRC_O(tsrc), .TAKEN_HIGH_O(thigh), .RESUME_O(resume), .LINK(link));
   imp_link_props imp_link_props_inst (.CLK_I(clk), .ARST_N_I(arst_n), .req_i(link.req),
      .src_id_i(link.src_id), .src_high_i(link.src_high), .ack_i(link.ack));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hung handshake must end the run rather than stall it.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] wd);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {18'h0, idx, 2'h0};
      dat_i <= {24'h000000, wd};
      // Only the bench timeout ends a wait for the answer.
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
      bus(idx, 1'b0, 8'h00);
      check("register", {24'h000000, rd}, {24'h000000, exp});
   endtask

   task automatic wait_hi(ref logic s);
      while (s !== 1'b1) begin
         @(posedge clk);
      end
   endtask

   initial begin
      arst_n = 1'b0;
      {cyc, stb, we, accept, hdone} = 5'h00;
      lvl = 16'h0000;
      edg = 8'h00;
      adr = 32'h00000000;
      dat_i = 32'h00000000;
      sel = 4'hF;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values, and unmapped places inside the span read zero.
      for (int i = 12'h640; i <= 12'h651; i++) rdc(i[11:0], 8'h00);
      bus(12'h642, 1'b1, 8'hFF);
      rdc(12'h642, 8'h7F);
      bus(12'h643, 1'b1, 8'hFF);
      rdc(12'h643, 8'h03);
      bus(12'h647, 1'b1, 8'hFF);
      rdc(12'h647, 8'h00);
      // Mixed masks over level sources; flags stay hidden until enabled.
      bus(12'h640, 1'b1, 8'h5A);
      bus(12'h641, 1'b1, 8'hFF);
      bus(12'h643, 1'b1, 8'h00);
      lvl <= 16'hA5C3;
      repeat (3) @(posedge clk);
      rdc(12'h648, 8'h00);
      check("req", link.req, 1'b0);
      bus(12'h643, 1'b1, 8'h01);
      rdc(12'h648, 8'h42);
      rdc(12'h649, 8'hA5);
      // A write without the low byte lane must leave the mask alone.
      sel <= 4'hE;
      bus(12'h641, 1'b1, 8'h00);
      sel <= 4'hF;
      rdc(12'h641, 8'hFF);
      bus(12'h648, 1'b1, 8'hFF);
      rdc(12'h648, 8'h42);
      lvl <= 16'h0000;
      repeat (3) @(posedge clk);
      rdc(12'h649, 8'h00);
      // Edge flags stick after the line falls; reserved bit never shows.
      edg <= 8'hFF;
      @(posedge clk);
      edg <= 8'h00;
      repeat (3) @(posedge clk);
      rdc(12'h64A, 8'h7F);
      bus(12'h64A, 1'b1, 8'h00);
      rdc(12'h64A, 8'h7F);
      bus(12'h64A, 1'b1, 8'h01);
      rdc(12'h64A, 8'h7E);
      bus(12'h64A, 1'b1, 8'h7E);
      rdc(12'h64A, 8'h00);
      // Counter0 low urgency against GPIO high urgency, both at once.
      bus(12'h640, 1'b1, 8'h01);
      bus(12'h642, 1'b1, 8'h04);
      bus(12'h646, 1'b1, 8'h04);
      rdc(12'h646, 8'h04);
      bus(12'h651, 1'b1, 8'h01);
      bus(12'h650, 1'b1, 8'h03);
      lvl <= 16'h0001;
      edg <= 8'h04;
      repeat (3) @(posedge clk);
      rdc(12'h648, 8'h01);
      check("irq idle", irq, 1'b0);
      accept <= 1'b1;
      wait_hi(in_h);
      accept <= 1'b0;
      check("taken src", tsrc, 5'h12);
      check("taken high", thigh, 1'b1);
      hdone <= 1'b1;
      wait_hi(resume);
      hdone <= 1'b0;
      check("resume", resume, 1'b1);
      @(posedge clk);
      check("resume pulse", resume, 1'b0);
      check("handler left", in_h, 1'b0);
      rdc(12'h650, 8'h03);
      check("irq set", irq, 1'b1);
      bus(12'h651, 1'b1, 8'h00);
      @(posedge clk);
      check("irq masked", irq, 1'b0);
      bus(12'h650, 1'b1, 8'h03);
      rdc(12'h650, 8'h00);
      bus(12'h64A, 1'b1, 8'h04);
      repeat (3) @(posedge clk);
      accept <= 1'b1;
      wait_hi(in_h);
      accept <= 1'b0;
      check("second src", tsrc, 5'h00);
      check("second high", thigh, 1'b0);
      hdone <= 1'b1;
      wait_hi(resume);
      hdone <= 1'b0;
      final_report();
   end
endmodule
`default_nettype wire
